// File: logic/adcwp_top.sv
`timescale 1ns/1ps
`include "adcwp_defines.svh"
// Functional notes
// - word mode: one write takes the full word, pin zero is the lsb
// - each finished word lands in the control or the shadow register
// - byte mode: bit-8 pin is high-byte enable, two writes per word
// - high-byte enable level tells low byte from high byte
// - write happens only while select and strobe are both low
// - data pins are captured at the strobe's rising edge
// - two power bits pick normal, full shutdown, auto shutdown, standby
// - reset leaves the control register in normal mode
// - normal mode keeps the core powered once it is on
// - full shutdown powers down and keeps settings until bits change
// - leaving full shutdown for normal powers up on next start rise
// - auto shutdown: down after each conversion, up on start rise
// - auto standby: all but reference down after each conversion
// - standby wakes on start rise, needs at least one microsecond
// - busy drops low when a conversion finishes
// - start fall begins a conversion when on or powering up (not in shutdown or standby), busy high throughout
module adcwp_top #(
  parameter int DATA_W = 12,
  parameter int CONV_CYC = `ADCWP_CONV_CYC,
  parameter int FULLUP_CYC = `ADCWP_FULLUP_CYC,
  parameter int UPINT_CYC = `ADCWP_UPINT_CYC,
  parameter int UPEXT_CYC = `ADCWP_UPEXT_CYC,
  parameter int STBY_CYC = `ADCWP_STBY_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic csN,
  input wire logic wrN,
  input wire logic wordByteSel,
  input wire logic [11:0] dataPins,
  input wire logic convStartPin,
  output logic busy,
  output logic corePowered,
  output logic refPowered
);

  localparam int CNT_W = 16;

  if (DATA_W != 12 && DATA_W != 10) begin : gBadWidth
    $error("adcwp_top: DATA_W must be 12 or 10");
  end
  if (CONV_CYC < 1 || FULLUP_CYC < 1 || UPINT_CYC < 1 ||
      UPEXT_CYC < 1 || STBY_CYC < 1) begin : gBadCount
    $error("adcwp_top: cycle counts must be at least one");
  end
  // longer waits would wrap the shared wait counter
  if (CONV_CYC >= 2**CNT_W || FULLUP_CYC >= 2**CNT_W ||
      UPINT_CYC >= 2**CNT_W || UPEXT_CYC >= 2**CNT_W ||
      STBY_CYC >= 2**CNT_W) begin : gBadRange
    $error("adcwp_top: cycle counts overflow the wait counter");
  end

  function automatic adcwp_pkg::adcwp_mode_t pmOf(
    input logic [11:0] ctrl
  );
    return adcwp_pkg::adcwp_mode_t'(
      {ctrl[`ADCWP_PM_HI_POS], ctrl[`ADCWP_PM_LO_POS]});
  endfunction : pmOf

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction : cyc

  //////////////////////////////////////////////////////////////////////////
  // pin write path

  adcwp_word_if #(.DATA_W(DATA_W)) wordBus ();

  adcwp_pin_port #(.DATA_W(DATA_W)) uPins (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .csN(csN),
    .wrN(wrN),
    .wordByteSel(wordByteSel),
    .dataPins(dataPins),
    .wordOut(wordBus.src)
  );

  logic [11:0] ctrl_r;
  logic [11:0] shadow_r;
  logic toShadow_r;
  logic [11:0] wordExt;

  assign wordExt = 12'(wordBus.word);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `ADCWP_CTRL_RST;
      shadow_r <= `ADCWP_SHADOW_RST;
    end else if (wordBus.wordValid) begin
      if (toShadow_r) begin
        shadow_r <= wordExt;
      end else begin
        ctrl_r <= wordExt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic dpValid_r;
  logic dpWrite_r;
  logic [7:0] dpAddr_r;
  logic addrPhase;
  logic regWrite;
  logic tgtWrite;
  logic stWrite;
  logic [31:0] rdValue;
  logic [31:0] statusWord;
  logic invalid_r;
  logic invalidSet;

  assign addrPhase = hsel && htrans[1] && hready;
  assign regWrite = dpValid_r && dpWrite_r;
  assign tgtWrite = regWrite && dpAddr_r == `ADCWP_OFS_TARGET;
  assign stWrite = regWrite && dpAddr_r == `ADCWP_OFS_STATUS;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpAddr_r <= 8'h00;
    end else if (hready) begin
      dpValid_r <= addrPhase;
      dpWrite_r <= hwrite;
      dpAddr_r <= {haddr[7:2], 2'b00};
    end
  end

  // zero-wait slave, never errors
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // shadow steering, cleared once a word has gone to the shadow;
  // a software set in the same cycle wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      toShadow_r <= 1'b0;
    end else if (tgtWrite) begin
      toShadow_r <= hwdata[`ADCWP_TGT_SHADOW];
    end else if (wordBus.wordValid && toShadow_r) begin
      toShadow_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      invalid_r <= 1'b0;
    end else if (invalidSet) begin
      invalid_r <= 1'b1;
    end else if (stWrite && hwdata[`ADCWP_ST_INVALID]) begin
      invalid_r <= 1'b0;
    end
  end

  always_comb begin
    rdValue = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      `ADCWP_OFS_CTRL: rdValue = {20'h00000, ctrl_r};
      `ADCWP_OFS_SHADOW: rdValue = {20'h00000, shadow_r};
      `ADCWP_OFS_TARGET: rdValue = {31'h0, toShadow_r};
      `ADCWP_OFS_STATUS: rdValue = statusWord;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdValue;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power modes and conversion timing

  adcwp_pkg::adcwp_pstate_t pst_r;
  logic [CNT_W-1:0] cnt_r;
  logic convPrev_r;
  logic convFall;
  logic convRise;
  logic wakePend_r;
  adcwp_pkg::adcwp_mode_t mode;
  adcwp_pkg::adcwp_mode_t modePrev_r;
  logic [CNT_W-1:0] upCnt;

  assign mode = pmOf(ctrl_r);
  assign convFall = convPrev_r && !convStartPin;
  assign convRise = !convPrev_r && convStartPin;
  // starting inside the power-up window yields bad data
  assign invalidSet = convFall && pst_r == adcwp_pkg::PS_UP;

  always_comb begin
    case (mode)
      adcwp_pkg::PM_STANDBY: upCnt = cyc(STBY_CYC);
      adcwp_pkg::PM_AUTO_SHUT: upCnt = ctrl_r[`ADCWP_REF_POS] ?
        cyc(UPEXT_CYC) : cyc(UPINT_CYC);
      default: upCnt = cyc(FULLUP_CYC);
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      convPrev_r <= 1'b1;
      modePrev_r <= adcwp_pkg::PM_NORMAL;
    end else begin
      convPrev_r <= convStartPin;
      modePrev_r <= mode;
    end
  end

  // wake from full shutdown waits for a start rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wakePend_r <= 1'b0;
    end else if (pst_r == adcwp_pkg::PS_SHUT &&
                 modePrev_r == adcwp_pkg::PM_FULL_SHUT &&
                 mode == adcwp_pkg::PM_NORMAL) begin
      wakePend_r <= 1'b1;
    end else if (pst_r != adcwp_pkg::PS_SHUT) begin
      wakePend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pst_r <= adcwp_pkg::PS_ON;
      cnt_r <= '0;
    end else begin
      case (pst_r)
        adcwp_pkg::PS_ON: begin
          if (mode == adcwp_pkg::PM_FULL_SHUT) begin
            pst_r <= adcwp_pkg::PS_SHUT;
          end else if (convFall) begin
            pst_r <= adcwp_pkg::PS_CONV;
            cnt_r <= cyc(CONV_CYC);
          end
        end
        adcwp_pkg::PS_CONV: begin
          if (cnt_r > cyc(1)) begin
            cnt_r <= cnt_r - cyc(1);
          end else begin
            case (mode)
              adcwp_pkg::PM_AUTO_SHUT: pst_r <= adcwp_pkg::PS_SHUT;
              adcwp_pkg::PM_STANDBY: pst_r <= adcwp_pkg::PS_STBY;
              adcwp_pkg::PM_FULL_SHUT: pst_r <= adcwp_pkg::PS_SHUT;
              default: pst_r <= adcwp_pkg::PS_ON;
            endcase
          end
        end
        adcwp_pkg::PS_SHUT: begin
          if (mode == adcwp_pkg::PM_FULL_SHUT) begin
            pst_r <= adcwp_pkg::PS_SHUT;
          end else if (convRise && (wakePend_r ||
                       mode != adcwp_pkg::PM_NORMAL)) begin
            pst_r <= adcwp_pkg::PS_UP;
            cnt_r <= upCnt;
          end
        end
        adcwp_pkg::PS_STBY: begin
          if (mode == adcwp_pkg::PM_FULL_SHUT) begin
            pst_r <= adcwp_pkg::PS_SHUT;
          end else if (convRise) begin
            pst_r <= adcwp_pkg::PS_UP;
            cnt_r <= upCnt;
          end
        end
        adcwp_pkg::PS_UP: begin
          if (convFall) begin
            // converts anyway; status flags the result as invalid
            pst_r <= adcwp_pkg::PS_CONV;
            cnt_r <= cyc(CONV_CYC);
          end else if (cnt_r > cyc(1)) begin
            cnt_r <= cnt_r - cyc(1);
          end else begin
            pst_r <= adcwp_pkg::PS_ON;
          end
        end
        default: begin
          pst_r <= adcwp_pkg::PS_ON;
        end
      endcase
    end
  end

  // pin outputs follow the state one cycle later, all from flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      corePowered <= 1'b1;
      refPowered <= 1'b1;
    end else begin
      busy <= pst_r == adcwp_pkg::PS_CONV;
      corePowered <= pst_r == adcwp_pkg::PS_ON ||
                     pst_r == adcwp_pkg::PS_CONV;
      refPowered <= pst_r != adcwp_pkg::PS_SHUT;
    end
  end

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`ADCWP_ST_BUSY] = busy;
    statusWord[`ADCWP_ST_CORE] = corePowered;
    statusWord[`ADCWP_ST_REF] = refPowered;
    statusWord[`ADCWP_ST_PM_LO+:2] = mode;
    statusWord[`ADCWP_ST_STATE_LO+:3] = pst_r;
    statusWord[`ADCWP_ST_WAKE] = wakePend_r;
    statusWord[`ADCWP_ST_INVALID] = invalid_r;
    statusWord[`ADCWP_ST_LOWPEND] = wordBus.lowPending;
  end

  logic unusedBits;
  assign unusedBits = ^{hsize, haddr[1:0], htrans[0]};

endmodule : adcwp_top

// File: logic/adcwp_defines.svh
`ifndef ADCWP_DEFINES_SVH
`define ADCWP_DEFINES_SVH

// register byte offsets
`define ADCWP_OFS_CTRL 8'h00
`define ADCWP_OFS_SHADOW 8'h04
`define ADCWP_OFS_TARGET 8'h08
`define ADCWP_OFS_STATUS 8'h0c

// control register fields
`define ADCWP_PM_LO_POS 4
`define ADCWP_PM_HI_POS 5
`define ADCWP_REF_POS 2
`define ADCWP_CTRL_RST 12'h030
`define ADCWP_SHADOW_RST 12'h000

// status register fields
`define ADCWP_ST_BUSY 0
`define ADCWP_ST_CORE 1
`define ADCWP_ST_REF 2
`define ADCWP_ST_PM_LO 3
`define ADCWP_ST_STATE_LO 5
`define ADCWP_ST_WAKE 8
`define ADCWP_ST_INVALID 9
`define ADCWP_ST_LOWPEND 10

// target register fields
`define ADCWP_TGT_SHADOW 0

// timing
`define ADCWP_CLK_NS 20
`define ADCWP_T_STBY_NS 1000
`define ADCWP_STBY_CYC ((`ADCWP_T_STBY_NS + `ADCWP_CLK_NS - 1) / `ADCWP_CLK_NS)
`define ADCWP_CONV_CYC 16
`define ADCWP_FULLUP_CYC 100
`define ADCWP_UPINT_CYC 80
`define ADCWP_UPEXT_CYC 60

`endif

// File: logic/adcwp_pkg.sv
package adcwp_pkg;

  typedef enum logic [1:0] {
    PM_STANDBY = 2'b00,
    PM_AUTO_SHUT = 2'b01,
    PM_FULL_SHUT = 2'b10,
    PM_NORMAL = 2'b11
  } adcwp_mode_t;

  typedef enum logic [2:0] {
    PS_ON = 3'b000,
    PS_CONV = 3'b001,
    PS_SHUT = 3'b010,
    PS_STBY = 3'b011,
    PS_UP = 3'b100
  } adcwp_pstate_t;

endpackage : adcwp_pkg

// File: logic/adcwp_word_if.sv
`timescale 1ns/1ps
interface adcwp_word_if #(parameter int DATA_W = 12);
  logic wordValid;
  logic [DATA_W-1:0] word;
  logic lowPending;

  modport src (output wordValid, output word, output lowPending);
  modport dst (input wordValid, input word, input lowPending);
endinterface : adcwp_word_if

// File: logic/adcwp_pin_port.sv
`timescale 1ns/1ps
// parallel write pins to assembled words
module adcwp_pin_port #(
  parameter int DATA_W = 12
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic csN,
  input wire logic wrN,
  input wire logic wordByteSel,
  input wire logic [11:0] dataPins,
  adcwp_word_if.src wordOut
);

  logic wrActPrev_r;
  logic wrAct;
  logic wrRise;
  logic [7:0] lowByte_r;
  logic lowPend_r;
  logic wordValid_r;
  logic [DATA_W-1:0] word_r;

  // high byte carries word bits 8 and up on the low pins
  if (DATA_W < 9 || DATA_W > 12) begin : gBadWidth
    $error("adcwp_pin_port: DATA_W must be 9 to 12");
  end

  assign wrAct = !csN && !wrN;
  // strobe release after a selected low strobe ends the write, whatever csN is then
  assign wrRise = wrActPrev_r && wrN;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrActPrev_r <= 1'b0;
    end else begin
      wrActPrev_r <= wrAct;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowByte_r <= 8'h00;
      lowPend_r <= 1'b0;
      wordValid_r <= 1'b0;
      word_r <= '0;
    end else begin
      wordValid_r <= 1'b0;
      if (wrRise) begin
        if (wordByteSel) begin
          word_r <= dataPins[DATA_W-1:0];
          wordValid_r <= 1'b1;
          lowPend_r <= 1'b0;
        end else if (!dataPins[8]) begin
          lowByte_r <= dataPins[7:0];
          lowPend_r <= 1'b1;
        end else begin
          // high byte: bit 8 of the word sits on data pin zero
          word_r <= {dataPins[DATA_W-9:0], lowByte_r};
          wordValid_r <= 1'b1;
          lowPend_r <= 1'b0;
        end
      end
    end
  end

  assign wordOut.wordValid = wordValid_r;
  assign wordOut.word = word_r;
  assign wordOut.lowPending = lowPend_r;

endmodule : adcwp_pin_port

// File: tb/adcwp_chk_sva.sv
`timescale 1ns/1ps
module adcwp_chk #(
  parameter int CONV_CYC = 16,
  parameter int FULLUP_CYC = 100,
  parameter int UPINT_CYC = 80,
  parameter int UPEXT_CYC = 60,
  parameter int STBY_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic convStartPin,
  input wire logic busy,
  input wire logic corePowered,
  input wire logic refPowered
);
  // shortest wake-up of all modes bounds any power-up
  localparam int MinA = (UPEXT_CYC < STBY_CYC) ? UPEXT_CYC : STBY_CYC;
  localparam int MinB = (UPINT_CYC < FULLUP_CYC) ? UPINT_CYC : FULLUP_CYC;
  localparam int MinUp = (MinA < MinB) ? MinA : MinB;
  int busyCnt;
  int riseAge;
  logic pinQ;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busyCnt <= 0;
      riseAge <= 0;
      pinQ <= 1'b1;
    end else begin
      busyCnt <= busy ? busyCnt + 1 : 0;
      pinQ <= convStartPin;
      riseAge <= (convStartPin && !pinQ) ? 0 : riseAge + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_busy_width: assert property (
    $fell(busy) |-> busyCnt == CONV_CYC) else $error("busy width off");
  chk_start_conv: assert property (
    $fell(convStartPin) && corePowered && !busy |-> ##2 $rose(busy))
    else $error("start fall gave no busy");
  chk_busy_cause: assert property (
    $rose(busy) |-> !$past(convStartPin, 2) && $past(convStartPin, 3))
    else $error("busy without start fall");
  chk_busy_powered: assert property (
    busy |-> corePowered) else $error("busy while core down");
  chk_core_ref: assert property (
    corePowered |-> refPowered) else $error("core up, ref down");
  chk_shut_ignore: assert property (
    !refPowered && $fell(convStartPin) |-> ##2 !busy)
    else $error("conversion in shutdown");
  chk_shut_exit: assert property (
    $rose(refPowered) |-> riseAge <= 3) else $error("woke without rise");
  chk_wake_delay: assert property (
    $rose(corePowered) |-> riseAge >= MinUp - 1)
    else $error("power-up too short");
endmodule : adcwp_chk
bind adcwp_top adcwp_chk #(.CONV_CYC(CONV_CYC), .FULLUP_CYC(FULLUP_CYC),
  .UPINT_CYC(UPINT_CYC), .UPEXT_CYC(UPEXT_CYC),
  .STBY_CYC(STBY_CYC)) chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .convStartPin(convStartPin), .busy(busy), .corePowered(corePowered),
  .refPowered(refPowered));

// File: tb/adcwp_host_model.sv
`timescale 1ns/1ps
module adcwp_host_model (
  input wire logic clk_sys,
  output logic csN,
  output logic wrN,
  output logic wordByteSel,
  output logic [11:0] dataPins,
  output logic convStartPin
);
  initial begin
    csN = 1'b1;
    wrN = 1'b1;
    wordByteSel = 1'b1;
    dataPins = 12'h000;
    convStartPin = 1'b1;
  end
  // the model owns every pin it drives; the bench asks through tasks
  task automatic setWordMode(input logic m);
    wordByteSel <= m;
  endtask : setWordMode
  task automatic setStart(input logic s);
    convStartPin <= s;
  endtask : setStart
  // sel low strobes a deselected part
  task automatic pinWrite(input logic sel, input logic [11:0] d);
    @(posedge clk_sys);
    csN <= !sel;
    wrN <= 1'b0;
    dataPins <= d;
    @(posedge clk_sys);
    csN <= 1'b1;
    wrN <= 1'b1;
    @(posedge clk_sys);
    // released bus must not echo the last word
    dataPins <= ~d;
    repeat (3) @(posedge clk_sys);
  endtask : pinWrite
endmodule : adcwp_host_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic csN, wrN, wordByteSel, convStartPin, busy, corePowered, refPowered;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] dataPins, w, v;
  int n;
  int nErrors = 0;
  int checksDone = 0;
  int cyc = 0;
  assign hready = hreadyout;
  adcwp_top #(.CONV_CYC(4), .FULLUP_CYC(4), .UPINT_CYC(4), .UPEXT_CYC(4))
    dut (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .csN, .wrN, .wordByteSel,
    .dataPins, .convStartPin, .busy, .corePowered, .refPowered);
  adcwp_host_model host (.clk_sys, .csN, .wrN, .wordByteSel, .dataPins,
    .convStartPin);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic printVerdict();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : printVerdict
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      nErrors++;
      printVerdict();
    end
  end
  task automatic check(input string what, input logic [31:0] got, exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick
  task automatic power(input logic c, input logic r);
    check("corePowered", corePowered, c);
    check("refPowered", refPowered, r);
  endtask : power
  // fixed window: conversion length is what is measured
  task automatic conv(output int cnt);
    host.setStart(1'b0);
    cnt = 0;
    repeat (20) begin
      @(posedge clk_sys);
      cnt += busy;
    end
  endtask : conv
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    void'($urandom(12));
    tick(20);
    arst_n <= 1'b1;
    tick(2);
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rd, 32'h030);
    power(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 12'hfff : 12'($urandom()) | 12'h030;
      host.pinWrite(1'b1, w);
      ahb(1'b0, 8'h00, 32'h0);
      check("ctrl word", rd, {20'h0, w});
    end
    ahb(1'b1, 8'h08, 32'h1);
    v = 12'($urandom());
    host.pinWrite(1'b1, v);
    ahb(1'b0, 8'h04, 32'h0);
    check("shadow", rd, {20'h0, v});
    host.pinWrite(1'b0, 12'h000);
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl kept", rd, {20'h0, w});
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    host.setWordMode(1'b0);
    v = 12'($urandom()) | 12'h030;
    host.pinWrite(1'b1, {4'h0, v[7:0]});
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl low byte", rd, {20'h0, w});
    host.pinWrite(1'b1, {3'h0, 1'b1, 4'h0, v[11:8]});
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl bytes", rd, {20'h0, v});
    host.setWordMode(1'b1);
    host.pinWrite(1'b1, 12'h030);
    conv(n);
    check("busy normal", n, 4);
    power(1'b1, 1'b1);
    host.setStart(1'b1);
    host.pinWrite(1'b1, 12'h010);
    conv(n);
    check("busy auto", n, 4);
    power(1'b0, 1'b0);
    host.setStart(1'b1);
    // rise seen one edge on, outputs trail the state by one more
    tick(3);
    power(1'b0, 1'b1);
    tick(10);
    power(1'b1, 1'b1);
    host.pinWrite(1'b1, 12'h000);
    conv(n);
    check("busy standby", n, 4);
    power(1'b0, 1'b1);
    host.setStart(1'b1);
    tick(50);
    power(1'b0, 1'b1);
    tick(10);
    power(1'b1, 1'b1);
    host.pinWrite(1'b1, 12'h020);
    tick(3);
    power(1'b0, 1'b0);
    conv(n);
    check("busy shut", n, 0);
    host.setStart(1'b1);
    tick(10);
    power(1'b0, 1'b0);
    host.pinWrite(1'b1, 12'h030);
    tick(10);
    power(1'b0, 1'b0);
    host.setStart(1'b0);
    tick(2);
    host.setStart(1'b1);
    tick(10);
    power(1'b1, 1'b1);
    conv(n);
    check("busy woken", n, 4);
    // on, normal mode, no stale flags once the host waited out power-up
    ahb(1'b0, 8'h0c, 32'h0);
    check("status", rd, 32'h0000_001e);
    printVerdict();
  end
endmodule : tb
